// *** logic/microseq_defs.svh ***
// constants for the microsequencer and literal-operation block
// assumes inclusion by bare name from every file that needs a number
`ifndef MICROSEQ_DEFS_SVH
`define MICROSEQ_DEFS_SVH

// microinstruction word and field positions
`define MI_W 17
`define MI_RLD_BIT 16
`define MI_GRP_HI 15
`define MI_GRP_LO 12
`define MI_OP_HI 15
`define MI_OP_LO 8
`define MI_RET_BIT 11
`define MI_JMP_HI 10
`define MI_JMP_LO 0
`define MI_LIT_HI 11
`define MI_LIT_LO 4
`define MI_RSEL_HI 3
`define MI_RSEL_LO 0
`define MI_TGT_HI 7
`define MI_TGT_LO 0

// location counter
`define CNT_W 11
`define CNT_RST 11'h000
`define CNT_PAGE_HI 10
`define CNT_PAGE_LO 8

// opcode groups and single opcodes
`define GRP_JUMP 4'h0
`define GRP_COND 4'h1
`define GRP_ADD 4'h2
`define GRP_CMP 4'h3
`define GRP_AND 4'h4
`define GRP_TEST 4'h5
`define GRP_LOAD 4'h6
`define GRP_MISC 4'h7
`define OP_INT_CLR 8'h70
`define OP_INT_SET 8'h71
`define OP_FLG_SAVE 8'h72
`define OP_FLG_LOAD 8'h73
`define OP_XST_CLR 8'h74

// byte alu selects
`define ALU_ADD 2'h0
`define ALU_SUB 2'h1
`define ALU_AND 2'h2

// bus register byte offsets
`define A_CTRL 8'h00
`define A_CNT 8'h04
`define A_FLAGS 8'h08
`define A_XST 8'h0c
`define A_STAT 8'h10
`define A_RF_BASE 8'h40
`define A_RF_END 8'h7c
`define HTRANS_NONSEQ 2'h2
`define HRESP_OKAY 1'b0
`define CTRL_RST 1'b0
`define RF_N 16

`endif

// *** logic/microseq_pkg.sv ***
// types shared by the microsequencer files
// assumes microseq_defs.svh supplies the numbers
package microseq_pkg;
    // condition flags, byte flags high, word flags low
    typedef struct packed {
        logic bneg;
        logic bzero;
        logic ncarry;
        logic bcarry;
        logic n;
        logic z;
        logic v;
        logic c;
    } flags_s;

    // one-hot sequencer states
    typedef enum logic [1:0] {
        ST_RUN = 2'b01,
        ST_HOLD = 2'b10
    } seq_state_e;
endpackage

// *** logic/byte_lit_alu.sv ***
// byte alu for the literal microinstructions
// assumes a purely combinational use inside one clocked datapath
`timescale 1ns/100ps
`include "microseq_defs.svh"
module byte_lit_alu #(
    parameter int W = 8
) (
    input wire logic [W-1:0] a_in,
    input wire logic [W-1:0] b_in,
    input wire logic [1:0] sel_in,
    output logic [W-1:0] res_out,
    output logic nib_carry_out,
    output logic byte_carry_out
);
    logic [W:0] wide; // sum with carry out
    logic [4:0] low_nib; // low nibble sum for nibble carry

    // one adder serves add and subtract, and passes through for and
    always_comb begin
        wide = '0;
        low_nib = '0;
        res_out = a_in & b_in;
        case (sel_in)
            `ALU_ADD: begin
                wide = {1'b0, a_in} + {1'b0, b_in};
                low_nib = {1'b0, a_in[3:0]} + {1'b0, b_in[3:0]};
                res_out = wide[W-1:0];
            end
            `ALU_SUB: begin
                wide = {1'b0, a_in} - {1'b0, b_in};
                res_out = wide[W-1:0];
            end
            default: begin
                res_out = a_in & b_in;
            end
        endcase
        nib_carry_out = low_nib[4];
        byte_carry_out = wide[W];
    end
endmodule

// *** logic/microseq_literal_ops.sv ***
// microsequencer with literal byte operations, reached over ahb-lite
// assumes the control store presents one microinstruction per accepted handshake
// Notes on behaviour
// - return loads counter from return register
// - add literal writes byte, sets byte flags
// - compare literal sets negative and zero only
// - and literal writes byte, sets two flags
// - test literal writes nothing, sets two flags
// - load literal writes byte, sets two flags
// - opcodes clear and set interrupt enable
// - flags saved to and loaded from register
// - opcode clears translation status register
// - conditional jump keeps incremented page bits
// - return-load bit saves incremented counter
// - return load beats control array translation
`timescale 1ns/100ps
`include "microseq_defs.svh"
module microseq_literal_ops (
    input wire logic ref_clk_in,
    input wire logic rst_in,
    input wire logic [`MI_W-1:0] mi_in,
    input wire logic mi_valid_in,
    input wire logic ext_cond_in,
    input wire logic xlat_req_in,
    input wire logic [`CNT_W-1:0] xlat_addr_in,
    input wire logic [7:0] xst_set_in,
    input wire logic hsel_in,
    input wire logic [31:0] haddr_in,
    input wire logic [1:0] htrans_in,
    input wire logic hwrite_in,
    input wire logic [2:0] hsize_in,
    input wire logic [31:0] hwdata_in,
    input wire logic hready_in,
    output logic [31:0] hrdata_out,
    output logic hreadyout_out,
    output logic hresp_out,
    output logic mi_ready_out,
    output logic [`CNT_W-1:0] location_counter_out,
    output logic int_enable_out,
    output logic [7:0] translation_status_register_out,
    output microseq_pkg::flags_s flags_out
);
    // sequencer state
    microseq_pkg::seq_state_e state_reg, state_next;
    logic [`CNT_W-1:0] location_counter_reg, location_counter_next; // next microaddress
    logic [`CNT_W-1:0] return_reg, return_next; // subroutine return address
    logic ready_reg, ready_next; // accepts a microinstruction
    microseq_pkg::flags_s flags_reg, flags_next;
    logic ie_reg, ie_next; // interrupt enable
    logic [7:0] xst_reg, xst_next;
    logic [7:0] rf_reg [`RF_N];
    logic [7:0] rf_next [`RF_N];
    // bus state
    logic run_reg, run_next; // software lets the sequencer run
    logic wr_pend_reg, wr_pend_next; // write data phase pending
    logic rd_pend_reg, rd_pend_next; // read data phase, first cycle
    logic [7:0] addr_reg, addr_next; // captured byte offset
    logic [31:0] hrdata_reg, hrdata_next;
    logic hready_reg, hready_next;

    // decode wires
    logic accept; // handshake with control store
    logic [3:0] grp;
    logic [7:0] op;
    logic [3:0] rsel;
    logic [7:0] lit;
    logic [7:0] rv; // selected register byte
    logic [`CNT_W-1:0] cnt_inc;
    logic [2:0] cnt_inc_top; // page bits of incremented counter
    logic cond_flag; // flag tested by a conditional jump
    logic [1:0] alu_sel;
    logic [7:0] alu_res;
    logic alu_nc;
    logic alu_bc;
    logic [31:0] rd_mux;
    logic bus_start;

    assign accept = mi_valid_in & ready_reg;
    assign grp = mi_in[`MI_GRP_HI:`MI_GRP_LO];
    assign op = mi_in[`MI_OP_HI:`MI_OP_LO];
    assign rsel = mi_in[`MI_RSEL_HI:`MI_RSEL_LO];
    assign lit = mi_in[`MI_LIT_HI:`MI_LIT_LO];
    assign rv = rf_reg[rsel];
    assign cnt_inc = location_counter_reg + `CNT_W'(1);
    assign cnt_inc_top = cnt_inc[`CNT_PAGE_HI:`CNT_PAGE_LO];
    assign bus_start = hsel_in & hready_in & (htrans_in == `HTRANS_NONSEQ);

    // flag picked by opcode bits 3:1, byte flags and external condition first then word flags
    always_comb begin
        case (op[3:1])
            3'h0: cond_flag = flags_reg.bzero;
            3'h1: cond_flag = flags_reg.bcarry;
            3'h2: cond_flag = ext_cond_in;
            3'h3: cond_flag = flags_reg.bneg;
            3'h4: cond_flag = flags_reg.z;
            3'h5: cond_flag = flags_reg.c;
            3'h6: cond_flag = flags_reg.v;
            default: cond_flag = flags_reg.n;
        endcase
    end

    // alu function from opcode group
    always_comb begin
        case (grp)
            `GRP_ADD: alu_sel = `ALU_ADD;
            `GRP_CMP: alu_sel = `ALU_SUB;
            default: alu_sel = `ALU_AND;
        endcase
    end

    byte_lit_alu #(.W(8)) alu_u (
        .a_in(rv),
        .b_in(lit),
        .sel_in(alu_sel),
        .res_out(alu_res),
        .nib_carry_out(alu_nc),
        .byte_carry_out(alu_bc)
    );

    // read mux, taken one cycle after the address so earlier writes show
    always_comb begin
        rd_mux = 32'h0000_0000;
        case (addr_reg)
            `A_CTRL: rd_mux[0] = run_reg;
            `A_CNT: rd_mux[`CNT_W-1:0] = location_counter_reg;
            `A_FLAGS: rd_mux[7:0] = flags_reg;
            `A_XST: rd_mux[7:0] = xst_reg;
            `A_STAT: rd_mux = {19'h0_0000, return_reg, ie_reg, ready_reg};
            default: begin
                if (addr_reg >= `A_RF_BASE && addr_reg <= `A_RF_END) begin
                    rd_mux[7:0] = rf_reg[addr_reg[5:2]];
                end
            end
        endcase
    end

    // bus slave: zero-wait writes, one wait state on reads
    always_comb begin
        wr_pend_next = 1'b0;
        rd_pend_next = 1'b0;
        addr_next = addr_reg;
        hrdata_next = hrdata_reg;
        hready_next = 1'b1;
        if (rd_pend_reg) begin
            hrdata_next = rd_mux; // data valid with hreadyout next cycle
        end else if (bus_start) begin
            addr_next = haddr_in[7:0];
            wr_pend_next = hwrite_in;
            rd_pend_next = ~hwrite_in;
            hready_next = hwrite_in; // stall one cycle for a read
        end
    end

    // sequencer and datapath next values
    always_comb begin
        state_next = microseq_pkg::ST_RUN;
        location_counter_next = location_counter_reg;
        return_next = return_reg;
        flags_next = flags_reg;
        ie_next = ie_reg;
        xst_next = xst_reg;
        rf_next = rf_reg;
        run_next = run_reg;
        // software writes first, so a microinstruction in the same cycle wins
        if (wr_pend_reg) begin
            if (addr_reg == `A_CTRL) begin
                run_next = hwdata_in[0];
            end else if (addr_reg == `A_XST) begin
                xst_next = hwdata_in[7:0];
            end else if (addr_reg >= `A_RF_BASE && addr_reg <= `A_RF_END) begin
                rf_next[addr_reg[5:2]] = hwdata_in[7:0];
            end
        end
        if (accept) begin
            location_counter_next = cnt_inc;
            // translation applies except where a jump or return owns the counter
            if (xlat_req_in && grp != `GRP_JUMP) begin
                location_counter_next = xlat_addr_in;
            end
            case (grp)
                `GRP_JUMP: begin
                    state_next = microseq_pkg::ST_HOLD;
                    if (mi_in[`MI_RET_BIT]) begin
                        location_counter_next = return_reg;
                    end else begin
                        location_counter_next = mi_in[`MI_JMP_HI:`MI_JMP_LO];
                        if (mi_in[`MI_RLD_BIT]) begin
                            return_next = cnt_inc;
                        end
                    end
                end
                `GRP_COND: begin
                    state_next = microseq_pkg::ST_HOLD;
                    // even jumps on 0, odd on 1; only jump and return beat a translation
                    if (cond_flag == op[0] && !xlat_req_in) begin
                        location_counter_next = {cnt_inc_top, mi_in[`MI_TGT_HI:`MI_TGT_LO]};
                    end
                end
                `GRP_ADD: begin
                    rf_next[rsel] = alu_res;
                    flags_next.bneg = alu_res[7];
                    flags_next.bzero = (alu_res == 8'h00);
                    flags_next.ncarry = alu_nc;
                    flags_next.bcarry = alu_bc;
                end
                `GRP_CMP, `GRP_TEST: begin
                    flags_next.bneg = alu_res[7];
                    flags_next.bzero = (alu_res == 8'h00);
                end
                `GRP_AND: begin
                    rf_next[rsel] = alu_res;
                    flags_next.bneg = alu_res[7];
                    flags_next.bzero = (alu_res == 8'h00);
                end
                `GRP_LOAD: begin
                    rf_next[rsel] = lit;
                    flags_next.bneg = lit[7];
                    flags_next.bzero = (lit == 8'h00);
                end
                `GRP_MISC: begin
                    case (op)
                        `OP_INT_CLR: ie_next = 1'b0;
                        `OP_INT_SET: ie_next = 1'b1;
                        `OP_FLG_SAVE: rf_next[rsel] = flags_reg;
                        `OP_FLG_LOAD: flags_next = rv;
                        `OP_XST_CLR: xst_next = 8'h00;
                        default: begin
                        end
                    endcase
                end
                default: begin
                    // other groups write no register or flag; only sequencing here
                end
            endcase
        end
        // translation logic sets bits sticky; a set beats a clear in the same cycle
        xst_next = xst_next | xst_set_in;
        ready_next = run_next && (state_next == microseq_pkg::ST_RUN);
    end

    // register everything
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            state_reg <= microseq_pkg::ST_RUN;
            location_counter_reg <= `CNT_RST;
            return_reg <= `CNT_RST;
            ready_reg <= 1'b0;
            flags_reg <= '0;
            ie_reg <= 1'b0;
            xst_reg <= 8'h00;
            for (int i = 0; i < `RF_N; i++) begin
                rf_reg[i] <= 8'h00;
            end
            run_reg <= `CTRL_RST;
            wr_pend_reg <= 1'b0;
            rd_pend_reg <= 1'b0;
            addr_reg <= 8'h00;
            hrdata_reg <= 32'h0000_0000;
            hready_reg <= 1'b1;
        end else begin
            state_reg <= state_next;
            location_counter_reg <= location_counter_next;
            return_reg <= return_next;
            ready_reg <= ready_next;
            flags_reg <= flags_next;
            ie_reg <= ie_next;
            xst_reg <= xst_next;
            rf_reg <= rf_next;
            run_reg <= run_next;
            wr_pend_reg <= wr_pend_next;
            rd_pend_reg <= rd_pend_next;
            addr_reg <= addr_next;
            hrdata_reg <= hrdata_next;
            hready_reg <= hready_next;
        end
    end

    assign hrdata_out = hrdata_reg;
    assign hreadyout_out = hready_reg;
    assign hresp_out = `HRESP_OKAY; // only okay is ever answered
    assign mi_ready_out = ready_reg;
    assign location_counter_out = location_counter_reg;
    assign int_enable_out = ie_reg;
    assign translation_status_register_out = xst_reg;
    assign flags_out = flags_reg;

    // checks on the sequencer
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (rst_in);

    jump_target_a: assert property (accept && grp == `GRP_JUMP && !mi_in[`MI_RET_BIT]
        |=> location_counter_reg == $past(mi_in[`MI_JMP_HI:`MI_JMP_LO]) && flags_reg == $past(flags_reg))
        else $error("jump target or flags wrong");
    return_load_a: assert property (accept && grp == `GRP_JUMP && mi_in[`MI_RET_BIT]
        |=> location_counter_reg == $past(return_reg) && !mi_ready_out)
        else $error("return did not load counter");
    jump_hold_a: assert property (accept && (grp == `GRP_JUMP || grp == `GRP_COND)
        |=> !mi_ready_out ##1 (mi_ready_out == run_reg))
        else $error("jump not two cycles");
    cond_page_a: assert property (accept && grp == `GRP_COND && !xlat_req_in
        |=> location_counter_reg[`CNT_PAGE_HI:`CNT_PAGE_LO] == $past(cnt_inc_top))
        else $error("conditional jump left its page");
    cond_sense_a: assert property (accept && grp == `GRP_COND && cond_flag != op[0] && !xlat_req_in
        |=> location_counter_reg == $past(cnt_inc))
        else $error("untaken jump moved counter");
    call_save_a: assert property (accept && grp == `GRP_JUMP && !mi_in[`MI_RET_BIT] && mi_in[`MI_RLD_BIT]
        |=> return_reg == $past(cnt_inc))
        else $error("call did not save return");
    add_write_a: assert property (accept && grp == `GRP_ADD
        |=> rf_reg[$past(rsel)] == $past(alu_res) && flags_reg.bcarry == $past(alu_bc)
            && flags_reg.v == $past(flags_reg.v))
        else $error("add literal wrong");
    cmp_nowrite_a: assert property (accept && (grp == `GRP_CMP || grp == `GRP_TEST)
        |=> rf_reg[$past(rsel)] == $past(rv) && flags_reg.bzero == ($past(alu_res) == 8'h00)
            && flags_reg.ncarry == $past(flags_reg.ncarry))
        else $error("compare or test wrote a register");
    load_lit_a: assert property (accept && grp == `GRP_LOAD
        |=> rf_reg[$past(rsel)] == $past(lit) && flags_reg.bneg == $past(lit[7]))
        else $error("load literal wrong");
    int_enable_a: assert property (accept && op == `OP_INT_CLR ##1 !(ready_reg && mi_valid_in && op == `OP_INT_SET)
        |-> !int_enable_out)
        else $error("interrupt enable not cleared");
    flag_save_a: assert property (accept && op == `OP_FLG_SAVE
        |=> rf_reg[$past(rsel)] == $past(flags_reg) && flags_reg == $past(flags_reg))
        else $error("flag save wrong");
    status_clear_a: assert property (accept && op == `OP_XST_CLR && xst_set_in == 8'h00
        |=> translation_status_register_out == 8'h00)
        else $error("status register not cleared");
    seq_step_a: assert property (accept && grp >= `GRP_ADD && !xlat_req_in
        |=> location_counter_reg == $past(cnt_inc))
        else $error("counter did not advance");
endmodule

// *** verification/control_store_model.sv ***
// control store model feeding the microinstruction port
// assumes the bench loads words into mem and raises issue_in to release them
`timescale 1ns/100ps
`include "microseq_defs.svh"
module control_store_model (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic [`CNT_W-1:0] location_counter_in,
    input wire logic mi_ready_in,
    input wire logic [7:0] issue_in,
    input wire logic slow_in,
    output logic [`MI_W-1:0] mi_out,
    output logic mi_valid_out
);
    // unloaded words hold a group 8 op, which only moves the counter on
    logic [`MI_W-1:0] mem [0:(1<<`CNT_W)-1];
    logic [7:0] taken_cnt; // words accepted so far
    logic [`CNT_W-1:0] prev_cnt; // counter seen a cycle ago
    logic fresh; // counter just moved, a slow store is still fetching

    initial begin
        for (int i = 0; i < (1 << `CNT_W); i++) begin
            mem[i] = 17'h08000;
        end
    end

    assign fresh = location_counter_in != prev_cnt;
    // offer only released words; once up, valid holds until taken
    assign mi_valid_out = (taken_cnt != issue_in) && !(slow_in && fresh);
    // idle bus shows the inverse, so a stale word never passes for a new one
    assign mi_out = mi_valid_out ? mem[location_counter_in] : ~mem[location_counter_in];

    // count accepted words and track the counter for the fetch delay
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            taken_cnt <= 8'h00;
            prev_cnt <= '0;
        end else begin
            prev_cnt <= location_counter_in;
            if (mi_valid_out && mi_ready_in) begin
                taken_cnt <= taken_cnt + 8'h01;
            end
        end
    end
endmodule

// *** verification/microseq_literal_ops_tb.sv ***
// self-checking bench for the microsequencer and literal operations
// assumes the control store model and the design files compile first
`timescale 1ns/100ps
`include "microseq_defs.svh"
module microsequencer_literal_ops_tb;
    logic ref_clk_in, rst_in, ext_cond, xlat_req, hsel, hwrite, slow, mi_valid;
    logic hreadyout, hresp, mi_ready, int_enable;
    logic [`MI_W-1:0] mi;
    logic [`CNT_W-1:0] xlat_addr, location_counter_out;
    logic [7:0] xst_set, issue, xst_out;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0] htrans;
    microseq_pkg::flags_s flags;
    int mismatches, total_checks;

    // design under test; one slave, so its hreadyout is the bus hready
    microseq_literal_ops dut_u (.ref_clk_in(ref_clk_in), .rst_in(rst_in), .mi_in(mi),
        .mi_valid_in(mi_valid), .ext_cond_in(ext_cond), .xlat_req_in(xlat_req), .xlat_addr_in(xlat_addr),
        .xst_set_in(xst_set), .hsel_in(hsel), .haddr_in(haddr), .htrans_in(htrans),
        .hwrite_in(hwrite), .hsize_in(3'h2), .hwdata_in(hwdata), .hready_in(hreadyout),
        .hrdata_out(hrdata), .hreadyout_out(hreadyout), .hresp_out(hresp),
        .mi_ready_out(mi_ready), .location_counter_out(location_counter_out),
        .int_enable_out(int_enable), .translation_status_register_out(xst_out),
        .flags_out(flags));

    // far side of the microinstruction port
    control_store_model cs_u (.clk_in(ref_clk_in), .rst_in(rst_in),
        .location_counter_in(location_counter_out), .mi_ready_in(mi_ready), .issue_in(issue),
        .slow_in(slow), .mi_out(mi), .mi_valid_out(mi_valid));

    always #5 ref_clk_in = ~ref_clk_in;

    task automatic summarize;
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // a wait that ran out ends the run
    task automatic give_up;
        mismatches++;
        $display("MISMATCH wait expected done seen timeout");
        summarize();
    endtask

    // one ahb-lite single: address phase held until hready, then data phase
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        int k;
        @(posedge ref_clk_in);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        k = 0;
        do begin @(posedge ref_clk_in); k++; end while (hreadyout !== 1'b1 && k < 50);
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= w ? d : 32'h0;
        do begin @(posedge ref_clk_in); k++; end while (hreadyout !== 1'b1 && k < 100);
        q = hrdata;
        if (k >= 100) give_up();
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask

    // release n words and return just after the clock edge that takes the last
    task automatic run(input int n);
        int k;
        @(posedge ref_clk_in);
        issue <= issue + 8'(n);
        k = 0;
        do begin @(posedge ref_clk_in); #1; k++; end while (cs_u.taken_cnt !== issue && k < 100);
        if (k >= 100) give_up();
    endtask

    // place one word at the current location and let it execute
    task automatic exec(input logic [`MI_W-1:0] w);
        cs_u.mem[location_counter_out] = w;
        run(1);
    endtask

    task automatic test_reset;
        logic [31:0] q;
        check("counter", 32'(location_counter_out), 32'h0);
        check("flags", 32'(flags), 32'h0);
        check("ie", 32'(int_enable), 32'h0);
        check("ready", 32'(mi_ready), 32'h0);
        check("hresp", 32'(hresp), 32'h0);
        bus(1'b0, 8'h20, 32'h0, q);
        check("unmapped", q, 32'h0);
        wr(8'h04, 32'h7ff);
        bus(1'b0, 8'h04, 32'h0, q);
        check("counter read only", q, 32'h0);
        wr(8'h00, 32'h1);
        $display("test reset done");
    endtask

    task automatic test_literal;
        logic [31:0] q;
        logic [10:0] l;
        logic [8:0] s;
        logic [4:0] h;
        logic [7:0] d;
        logic [7:0] fl;
        wr(8'h4c, 32'hf8);
        l = location_counter_out;
        exec({1'b0, 4'h2, 8'h09, 4'h3});
        s = 9'h0f8 + 9'h009;
        h = 5'h08 + 5'h09;
        fl = {s[7], s[7:0] == 8'h00, h[4], s[8], 4'h0};
        check("add flags", 32'(flags), 32'(fl));
        check("add ready", 32'(mi_ready), 32'h1);
        exec({1'b0, 4'h3, 8'h01, 4'h3});
        d = s[7:0] - 8'h01;
        fl = {d[7], d == 8'h00, fl[5:4], 4'h0};
        check("cmp flags", 32'(flags), 32'(fl));
        exec({1'b0, 4'h4, 8'h80, 4'h3});
        d = s[7:0] & 8'h80;
        fl = {d[7], d == 8'h00, fl[5:4], 4'h0};
        check("and flags", 32'(flags), 32'(fl));
        bus(1'b0, 8'h4c, 32'h0, q);
        check("and result", q, 32'(d));
        exec({1'b0, 4'h6, 8'h85, 4'h4});
        fl = {1'b1, 1'b0, fl[5:4], 4'h0};
        check("load flags", 32'(flags), 32'(fl));
        exec({1'b0, 4'h5, 8'h7a, 4'h4});
        d = 8'h85 & 8'h7a;
        fl = {d[7], d == 8'h00, fl[5:4], 4'h0};
        check("test flags", 32'(flags), 32'(fl));
        bus(1'b0, 8'h50, 32'h0, q);
        check("load result", q, 32'h85);
        check("seq counter", 32'(location_counter_out), 32'(l + 11'h5));
        $display("test literal done");
    endtask

    // slow store here, but each word is released after the counter has settled, so none waits
    task automatic test_misc;
        logic [31:0] q;
        logic [7:0] f;
        @(posedge ref_clk_in);
        slow <= 1'b1;
        xst_set <= 8'h3c;
        @(posedge ref_clk_in);
        xst_set <= 8'h00;
        @(posedge ref_clk_in);
        #1;
        check("status set", 32'(xst_out), 32'h3c);
        f = flags;
        exec({1'b0, 8'h74, 8'h00});
        check("status clear", 32'(xst_out), 32'h0);
        check("status flags", 32'(flags), 32'(f));
        wr(8'h58, 32'ha5);
        exec({1'b0, 8'h73, 8'h06});
        check("flags load", 32'(flags), 32'ha5);
        exec({1'b0, 8'h71, 8'h00});
        check("ie set", 32'(int_enable), 32'h1);
        exec({1'b0, 8'h70, 8'h00});
        check("ie clear", 32'(int_enable), 32'h0);
        check("ie flags", 32'(flags), 32'ha5);
        exec({1'b0, 8'h72, 8'h05});
        bus(1'b0, 8'h54, 32'h0, q);
        check("flags save", q, 32'ha5);
        @(posedge ref_clk_in);
        slow <= 1'b0;
        $display("test misc done");
    endtask

    // every conditional code, both external condition levels, each from the last page slot
    task automatic test_jumps;
        logic [31:0] q;
        logic [7:0] vec;
        logic [7:0] op;
        logic [10:0] exp;
        logic [10:0] ret;
        microseq_pkg::flags_s f;
        for (int p = 0; p < 2; p++) begin
            @(posedge ref_clk_in);
            ext_cond <= p[0];
            for (int i = 0; i < 16; i++) begin
                f = flags;
                exec({1'b0, 4'h0, 1'b0, 11'h0ff});
                check("jump counter", 32'(location_counter_out), 32'h0ff);
                check("jump bubble", 32'(mi_ready), 32'h0);
                check("jump flags", 32'(flags), 32'(f));
                op = 8'h10 + 8'(i);
                vec = {f.n, f.v, f.c, f.z, f.bneg, p[0], f.bcarry, f.bzero};
                exp = (vec[op[3:1]] == op[0]) ? {3'h1, 8'h40 + 8'(i)} : 11'h100;
                exec({1'b0, op, 8'h40 + 8'(i)});
                check("cond counter", 32'(location_counter_out), 32'(exp));
                check("cond bubble", 32'(mi_ready), 32'h0);
            end
        end
        ret = location_counter_out + 11'h1;
        @(posedge ref_clk_in);
        xlat_req <= 1'b1;
        xlat_addr <= 11'h555;
        exec({1'b1, 4'h0, 1'b0, 11'h123});
        check("call counter", 32'(location_counter_out), 32'h123);
        bus(1'b0, 8'h10, 32'h0, q);
        check("return reg", {21'h0, q[12:2]}, 32'(ret));
        exec({1'b0, 4'h0, 1'b1, 11'h000});
        check("return counter", 32'(location_counter_out), 32'(ret));
        check("return bubble", 32'(mi_ready), 32'h0);
        // a plain literal op under translation takes the translated address
        exec({1'b0, 4'h6, 8'h00, 4'h7});
        check("xlat counter", 32'(location_counter_out), 32'h555);
        @(posedge ref_clk_in);
        xlat_req <= 1'b0;
        $display("test jumps done");
    endtask

    initial begin
        ref_clk_in = 1'b0;
        rst_in = 1'b1;
        ext_cond = 1'b0;
        xlat_req = 1'b0;
        xlat_addr = '0;
        xst_set = 8'h00;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hwdata = 32'h0;
        slow = 1'b0;
        issue = 8'h00;
        mismatches = 0;
        total_checks = 0;
        repeat (8) @(posedge ref_clk_in);
        rst_in <= 1'b0;
        @(posedge ref_clk_in);
        #1;
        test_reset();
        test_literal();
        test_misc();
        test_jumps();
        summarize();
    end
endmodule
